// ==== common/fadm_pkg.sv ====
// shared constants, opcodes and command decode for the serial flash front end
package fadm_pkg;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_READ_4B = 8'h13;
  localparam logic [7:0] OP_FAST = 8'h0B;
  localparam logic [7:0] OP_FAST_4B = 8'h0C;
  localparam logic [7:0] OP_QOUT = 8'h6B;
  localparam logic [7:0] OP_QOUT_4B = 8'h6C;
  localparam logic [7:0] OP_QIO = 8'hEB;
  localparam logic [7:0] OP_QIO_4B = 8'hEC;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_SECTOR_ERASE_4B = 8'h21;
  localparam logic [7:0] OP_HALF_BLOCK_ERASE = 8'h52;
  localparam logic [7:0] OP_HALF_BLOCK_ERASE_4B = 8'h5C;
  localparam logic [7:0] OP_BLOCK_ERASE = 8'hD8;
  localparam logic [7:0] OP_BLOCK_ERASE_4B = 8'hDC;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'hC7;
  localparam logic [7:0] OP_ENTER_QUAD = 8'h35;
  localparam logic [7:0] OP_QUAD_RESET = 8'hF5;
  localparam logic [7:0] OP_ENTER_WIDE = 8'hB7;
  localparam logic [7:0] OP_EXIT_WIDE = 8'hE9;
  localparam logic [31:0] ADDR_MASK = 32'h01FFFFFF;
  localparam int SEG_BIT = 24;
  localparam int CFG_WIDE_BIT = 5;
  localparam int CFG_DC_LSB = 6;
  localparam logic [1:0] DC_RESET = 2'h0;
  localparam logic WIDE_RESET = 1'b0;
  localparam logic QUAD_RESET_VAL = 1'b0;
  localparam logic SEG_RESET = 1'b0;
  localparam logic [1:0] HOST_HALF = 2'h3;
  typedef enum logic [3:0] {
    K_NONE, K_READ, K_ENTER_WIDE, K_EXIT_WIDE, K_ENTER_QUAD, K_QUAD_RESET,
    K_SECTOR, K_HALF_BLOCK, K_BLOCK, K_CHIP
  } fadm_kind_type;
  typedef struct packed {
    logic valid;
    fadm_kind_type kind;
    logic has_addr;
    logic force4;
    logic addr_quad;
    logic data_quad;
    logic dummy;
  } fadm_dec_type;
  function automatic logic [4:0] fadm_dummy_cycles(input logic [1:0] dc);
    case (dc)
      2'h1: fadm_dummy_cycles = 5'h06;
      2'h3: fadm_dummy_cycles = 5'h0A;
      default: fadm_dummy_cycles = 5'h08;
    endcase
  endfunction
  function automatic fadm_dec_type fadm_decode(input logic [7:0] op, input logic quad);
    fadm_dec_type d;
    d = '0;
    d.valid = 1'b1;
    d.addr_quad = quad;
    d.data_quad = quad;
    case (op)
      OP_READ, OP_READ_4B, OP_FAST, OP_FAST_4B, OP_QOUT, OP_QOUT_4B: begin
        d.valid = !quad;
        d.kind = K_READ;
        d.has_addr = 1'b1;
        d.force4 = op[4] | op[2];
        d.dummy = op[3];
        d.data_quad = op[6];
      end
      OP_QIO, OP_QIO_4B: begin
        d.kind = K_READ;
        d.has_addr = 1'b1;
        d.force4 = op[2];
        d.dummy = 1'b1;
        d.addr_quad = 1'b1;
        d.data_quad = 1'b1;
      end
      OP_SECTOR_ERASE, OP_SECTOR_ERASE_4B: begin
        d.kind = K_SECTOR;
        d.has_addr = 1'b1;
        d.force4 = op[0];
      end
      OP_HALF_BLOCK_ERASE, OP_HALF_BLOCK_ERASE_4B, OP_BLOCK_ERASE, OP_BLOCK_ERASE_4B: begin
        d.kind = op[7] ? K_BLOCK : K_HALF_BLOCK;
        d.has_addr = 1'b1;
        d.force4 = op[2];
      end
      OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: d.kind = K_CHIP;
      OP_ENTER_WIDE: d.kind = K_ENTER_WIDE;
      OP_EXIT_WIDE: d.kind = K_EXIT_WIDE;
      OP_ENTER_QUAD: begin
        d.kind = K_ENTER_QUAD;
        d.valid = !quad;
      end
      OP_QUAD_RESET: d.kind = K_QUAD_RESET;
      default: d.valid = 1'b0;
    endcase
    return d;
  endfunction
endpackage

// ==== common/fadm_link_if.sv ====
// serial link between host controller and flash front end
`timescale 1ns/1ps
interface fadm_link_if;
  logic cs_n;
  logic sclk;
  logic [3:0] h_out;
  logic [3:0] h_oe;
  logic [3:0] d_out;
  logic [3:0] d_oe;
  logic [3:0] io;
  // undriven lanes read high, as with a pull-up
  for (genvar i = 0; i < 4; i++) begin : g_lane
    assign io[i] = h_oe[i] ? h_out[i] : (d_oe[i] ? d_out[i] : 1'b1);
  end
  modport host (output cs_n, output sclk, output h_out, output h_oe, input io);
  modport dev (input cs_n, input sclk, input io, output d_out, output d_oe);
endinterface

// ==== src/fadm_device.sv ====
// flash end: address mode, four-line mode and opcode decode
`timescale 1ns/1ps
module fadm_device (
  fadm_link_if.dev lnk,
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ear_we,
  input wire logic [7:0] i_ear_wdata,
  output logic [7:0] o_ear_rdata,
  input wire logic i_cfg_we,
  input wire logic [7:0] i_cfg_wdata,
  output logic [7:0] o_cfg_rdata,
  output logic o_quad_mode,
  output logic [31:0] o_mem_addr,
  input wire logic [7:0] i_mem_data,
  output logic o_erase_req,
  output fadm_pkg::fadm_kind_type o_erase_kind,
  output logic [31:0] o_erase_addr
);
  typedef enum logic [2:0] {
    ST_CMD = 3'h0,
    ST_ADDR = 3'h1,
    ST_DUMMY = 3'h3,
    ST_DATA = 3'h2,
    ST_HOLD = 3'h6,
    ST_IGNORE = 3'h7
  } fadm_dev_st_type;

  // system-side mode state
  logic wide_r, wide_nxt;
  logic quad_r, quad_nxt;
  logic seg_r, seg_nxt;
  logic [1:0] dc_r, dc_nxt;
  logic cs_s1_r, cs_s2_r, cs_s3_r;
  logic erq_r, erq_nxt;
  fadm_pkg::fadm_kind_type ekind_r, ekind_nxt;
  logic [31:0] eaddr_r, eaddr_nxt;

  // link-side frame state, cleared while deselected
  fadm_dev_st_type st_r, st_nxt;
  logic [5:0] cnt_r, cnt_nxt;
  logic [31:0] sh_r, sh_nxt;
  fadm_pkg::fadm_dec_type dec_r, dec_nxt;
  logic [31:0] addr_r, addr_nxt;
  logic [2:0] dptr_r, dptr_nxt;
  logic [3:0] dout_r, dout_nxt;
  logic [3:0] doe_r, doe_nxt;

  // link-side result held across deselect for the system side
  fadm_pkg::fadm_kind_type pkind_r, pkind_nxt;
  logic [31:0] paddr_r, paddr_nxt;
  logic [2:0] ptot_r, ptot_nxt;

  logic lane4;
  logic [2:0] lanes;
  logic [5:0] cnt_sum;
  logic [31:0] shifted;
  logic [5:0] abits;
  logic [31:0] resolved;
  fadm_pkg::fadm_dec_type dcd;

  always_comb begin
    case (st_r)
      ST_ADDR: lane4 = dec_r.addr_quad;
      ST_DATA: lane4 = dec_r.data_quad;
      default: lane4 = quad_r;
    endcase
    lanes = lane4 ? 3'h4 : 3'h1;
    cnt_sum = cnt_r + {3'h0, lanes};
    shifted = lane4 ? {sh_r[27:0], lnk.io[3:0]} : {sh_r[30:0], lnk.io[0]};
    abits = (dec_r.force4 || wide_r) ? 6'h20 : 6'h18;
    if (abits == 6'h20) begin
      resolved = shifted & fadm_pkg::ADDR_MASK;
    end else begin
      resolved = {7'h00, seg_r, shifted[23:0]};
    end
    dcd = fadm_pkg::fadm_decode(shifted[7:0], quad_r);
  end

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_sum;
    sh_nxt = sh_r;
    dec_nxt = dec_r;
    addr_nxt = addr_r;
    dptr_nxt = dptr_r;
    pkind_nxt = pkind_r;
    paddr_nxt = paddr_r;
    ptot_nxt = ptot_r + lanes;
    if (st_r == ST_CMD && cnt_r == 6'h00) begin
      pkind_nxt = fadm_pkg::K_NONE;
      ptot_nxt = lanes;
    end
    case (st_r)
      ST_CMD: begin
        sh_nxt = shifted;
        if (cnt_sum == 6'h08) begin
          dec_nxt = dcd;
          cnt_nxt = 6'h00;
          if (!dcd.valid) begin
            st_nxt = ST_IGNORE;
          end else if (dcd.has_addr) begin
            st_nxt = ST_ADDR;
          end else begin
            st_nxt = ST_HOLD;
            pkind_nxt = dcd.kind;
          end
        end
      end
      ST_ADDR: begin
        sh_nxt = shifted;
        if (cnt_sum == abits) begin
          cnt_nxt = 6'h00;
          addr_nxt = resolved;
          if (dec_r.kind != fadm_pkg::K_READ) begin
            st_nxt = ST_HOLD;
            pkind_nxt = dec_r.kind;
            paddr_nxt = resolved;
          end else if (dec_r.dummy) begin
            st_nxt = ST_DUMMY;
          end else begin
            st_nxt = ST_DATA;
          end
        end
      end
      ST_DUMMY: begin
        cnt_nxt = cnt_r + 6'h01;
        if (cnt_nxt[4:0] == fadm_pkg::fadm_dummy_cycles(dc_r)) begin
          st_nxt = ST_DATA;
        end
      end
      ST_DATA: begin
        cnt_nxt = cnt_r;
        dptr_nxt = dptr_r + lanes;
        if (dptr_nxt == 3'h0) begin
          addr_nxt = (addr_r + 32'h1) & fadm_pkg::ADDR_MASK;
        end
      end
      default: cnt_nxt = cnt_r;
    endcase
  end

  always_ff @(posedge lnk.sclk or posedge lnk.cs_n) begin
    if (lnk.cs_n) begin
      st_r <= ST_CMD;
      cnt_r <= 6'h00;
      sh_r <= 32'h0;
      dec_r <= '0;
      addr_r <= 32'h0;
      dptr_r <= 3'h0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      dec_r <= dec_nxt;
      addr_r <= addr_nxt;
      dptr_r <= dptr_nxt;
    end
  end

  // survives deselect; kind and lane count rewritten at the first edge of every frame, address only when one completes
  always_ff @(posedge lnk.sclk) begin
    pkind_r <= pkind_nxt;
    paddr_r <= paddr_nxt;
    ptot_r <= ptot_nxt;
  end

  always_comb begin
    dout_nxt = 4'h0;
    doe_nxt = 4'h0;
    if (st_r == ST_DATA) begin
      if (dec_r.data_quad) begin
        doe_nxt = 4'hF;
        dout_nxt = dptr_r[2] ? i_mem_data[3:0] : i_mem_data[7:4];
      end else begin
        doe_nxt = 4'h2;
        dout_nxt = {2'h0, i_mem_data[3'h7 - dptr_r], 1'b0};
      end
    end
  end

  // output launched on the falling edge
  always_ff @(negedge lnk.sclk or posedge lnk.cs_n) begin
    if (lnk.cs_n) begin
      dout_r <= 4'h0;
      doe_r <= 4'h0;
    end else begin
      dout_r <= dout_nxt;
      doe_r <= doe_nxt;
    end
  end

  // system side: commit on deselect. pending result is quiet by then since
  // the link clock has stopped, so it is read as a static word.
  always_comb begin
    wide_nxt = wide_r;
    quad_nxt = quad_r;
    seg_nxt = seg_r;
    dc_nxt = dc_r;
    erq_nxt = 1'b0;
    ekind_nxt = ekind_r;
    eaddr_nxt = eaddr_r;
    if (i_ear_we) begin
      seg_nxt = i_ear_wdata[0];
    end
    if (i_cfg_we) begin
      dc_nxt = i_cfg_wdata[fadm_pkg::CFG_DC_LSB +: 2];
    end
    if (cs_s2_r && !cs_s3_r && ptot_r == 3'h0) begin
      case (pkind_r)
        fadm_pkg::K_ENTER_WIDE: wide_nxt = 1'b1;
        fadm_pkg::K_EXIT_WIDE: wide_nxt = 1'b0;
        fadm_pkg::K_ENTER_QUAD: quad_nxt = 1'b1;
        fadm_pkg::K_QUAD_RESET: quad_nxt = 1'b0;
        fadm_pkg::K_SECTOR, fadm_pkg::K_HALF_BLOCK, fadm_pkg::K_BLOCK: begin
          erq_nxt = 1'b1;
          ekind_nxt = pkind_r;
          eaddr_nxt = paddr_r;
        end
        fadm_pkg::K_CHIP: begin
          erq_nxt = 1'b1;
          ekind_nxt = pkind_r;
          eaddr_nxt = 32'h0;
        end
        default: erq_nxt = 1'b0;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wide_r <= fadm_pkg::WIDE_RESET;
      quad_r <= fadm_pkg::QUAD_RESET_VAL;
      seg_r <= fadm_pkg::SEG_RESET;
      dc_r <= fadm_pkg::DC_RESET;
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      cs_s3_r <= 1'b1;
      erq_r <= 1'b0;
      ekind_r <= fadm_pkg::K_NONE;
      eaddr_r <= 32'h0;
    end else begin
      wide_r <= wide_nxt;
      quad_r <= quad_nxt;
      seg_r <= seg_nxt;
      dc_r <= dc_nxt;
      cs_s1_r <= lnk.cs_n;
      cs_s2_r <= cs_s1_r;
      cs_s3_r <= cs_s2_r;
      erq_r <= erq_nxt;
      ekind_r <= ekind_nxt;
      eaddr_r <= eaddr_nxt;
    end
  end

  assign lnk.d_out = dout_r;
  assign lnk.d_oe = doe_r;
  assign o_mem_addr = addr_r;
  assign o_ear_rdata = {7'h00, seg_r};
  assign o_cfg_rdata = {dc_r, wide_r, 5'h00};
  assign o_quad_mode = quad_r;
  assign o_erase_req = erq_r;
  assign o_erase_kind = ekind_r;
  assign o_erase_addr = eaddr_r;
endmodule

// ==== src/fadm_host.sv ====
// host end: drives chip select, divided clock and command bytes
`timescale 1ns/1ps
module fadm_host (
  fadm_link_if.host lnk,
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic [7:0] i_opcode,
  input wire logic [31:0] i_addr,
  input wire logic [7:0] i_len,
  input wire logic i_quad_mode,
  input wire logic i_wide_mode,
  input wire logic [1:0] i_dummy_code,
  output logic o_busy,
  output logic [7:0] o_rd_data,
  output logic o_rd_valid,
  output logic o_done
);
  typedef enum logic [2:0] {
    H_IDLE = 3'h0,
    H_CMD = 3'h1,
    H_ADDR = 3'h3,
    H_DUMMY = 3'h2,
    H_DATA = 3'h6,
    H_END = 3'h7
  } fadm_host_st_type;

  fadm_host_st_type st_r, st_nxt;
  fadm_pkg::fadm_dec_type dec_r, dec_nxt;
  fadm_pkg::fadm_dec_type dcd;
  logic [10:0] cnt_r, cnt_nxt;
  logic [10:0] dcyc_r, dcyc_nxt;
  logic [4:0] dum_r, dum_nxt;
  logic [5:0] acyc_r, acyc_nxt;
  logic [39:0] tx_r, tx_nxt;
  logic [7:0] rx_r, rx_nxt;
  logic [2:0] rxn_r, rxn_nxt;
  logic [7:0] rd_r, rd_nxt;
  logic rdv_r, rdv_nxt;
  logic done_r, done_nxt;
  logic quad_r, quad_nxt;
  logic sclk_r, sclk_nxt;
  logic cs_r, cs_nxt;
  logic [1:0] hc_r, hc_nxt;
  logic [2:0] last_r, last_nxt;
  logic [3:0] io_s1_r, io_s2_r;
  logic [3:0] hout_r, hout_nxt;
  logic [3:0] hoe_r, hoe_nxt;
  logic lane4, wrap, wide;

  always_comb begin
    dcd = fadm_pkg::fadm_decode(i_opcode, i_quad_mode);
    wide = dcd.force4 || i_wide_mode;
    case (st_r)
      H_ADDR: lane4 = dec_r.addr_quad;
      H_DATA: lane4 = dec_r.data_quad;
      default: lane4 = quad_r;
    endcase
    wrap = (st_r != H_IDLE) && (hc_r == fadm_pkg::HOST_HALF);
  end

  always_comb begin
    st_nxt = st_r;
    dec_nxt = dec_r;
    cnt_nxt = cnt_r;
    dcyc_nxt = dcyc_r;
    dum_nxt = dum_r;
    acyc_nxt = acyc_r;
    tx_nxt = tx_r;
    rx_nxt = rx_r;
    rxn_nxt = rxn_r;
    rd_nxt = rd_r;
    rdv_nxt = 1'b0;
    done_nxt = 1'b0;
    quad_nxt = quad_r;
    sclk_nxt = sclk_r;
    cs_nxt = cs_r;
    last_nxt = last_r;
    hout_nxt = hout_r;
    hoe_nxt = hoe_r;
    hc_nxt = (st_r == H_IDLE || wrap) ? 2'h0 : hc_r + 2'h1;
    if (st_r == H_IDLE) begin
      if (i_start) begin
        st_nxt = H_CMD;
        cs_nxt = 1'b0;
        dec_nxt = dcd;
        quad_nxt = i_quad_mode;
        cnt_nxt = i_quad_mode ? 11'h002 : 11'h008;
        tx_nxt = wide ? {i_opcode, i_addr} : {i_opcode, i_addr[23:0], 8'h00};
        hout_nxt = i_quad_mode ? tx_nxt[39:36] : {3'h0, tx_nxt[39]};
        hoe_nxt = i_quad_mode ? 4'hF : 4'h1;
        acyc_nxt = (wide ? 6'h20 : 6'h18) >> (dcd.addr_quad ? 2 : 0);
        dum_nxt = fadm_pkg::fadm_dummy_cycles(i_dummy_code);
        dcyc_nxt = {i_len, 3'h0} >> (dcd.data_quad ? 2 : 0);
      end
    end else if (wrap && sclk_r) begin
      // falling edge: present next unit, or deselect after the last byte
      sclk_nxt = 1'b0;
      tx_nxt = (last_r == 3'h4) ? {tx_r[35:0], 4'h0} : {tx_r[38:0], 1'b0};
      hout_nxt = 4'h0;
      hoe_nxt = 4'h0;
      if (st_r == H_CMD || st_r == H_ADDR) begin
        hout_nxt = lane4 ? tx_nxt[39:36] : {3'h0, tx_nxt[39]};
        hoe_nxt = lane4 ? 4'hF : 4'h1;
      end
      if (st_r == H_END) begin
        cs_nxt = 1'b1;
        st_nxt = H_IDLE;
        done_nxt = 1'b1;
      end
    end else if (wrap) begin
      // rising edge: device samples, host samples returned data
      sclk_nxt = 1'b1;
      last_nxt = lane4 ? 3'h4 : 3'h1;
      cnt_nxt = cnt_r - 11'h001;
      if (st_r == H_DATA) begin
        rx_nxt = lane4 ? {rx_r[3:0], io_s2_r} : {rx_r[6:0], io_s2_r[1]};
        rxn_nxt = rxn_r + last_nxt;
        if (rxn_nxt == 3'h0) begin
          rd_nxt = rx_nxt;
          rdv_nxt = 1'b1;
        end
      end
      if (cnt_r == 11'h001) begin
        case (st_r)
          H_CMD: begin
            st_nxt = dec_r.has_addr ? H_ADDR : H_END;
            cnt_nxt = {5'h00, acyc_r};
          end
          H_ADDR: begin
            if (dec_r.kind != fadm_pkg::K_READ) begin
              st_nxt = H_END;
            end else if (dec_r.dummy) begin
              st_nxt = H_DUMMY;
              cnt_nxt = {6'h00, dum_r};
            end else begin
              st_nxt = H_DATA;
              cnt_nxt = dcyc_r;
            end
          end
          H_DUMMY: begin
            st_nxt = H_DATA;
            cnt_nxt = dcyc_r;
          end
          default: st_nxt = H_END;
        endcase
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_r <= H_IDLE;
      dec_r <= '0;
      cnt_r <= 11'h000;
      dcyc_r <= 11'h000;
      dum_r <= 5'h00;
      acyc_r <= 6'h00;
      tx_r <= 40'h0;
      rx_r <= 8'h00;
      rxn_r <= 3'h0;
      rd_r <= 8'h00;
      rdv_r <= 1'b0;
      done_r <= 1'b0;
      quad_r <= 1'b0;
      sclk_r <= 1'b0;
      cs_r <= 1'b1;
      hc_r <= 2'h0;
      last_r <= 3'h1;
      io_s1_r <= 4'hF;
      io_s2_r <= 4'hF;
      hout_r <= 4'h0;
      hoe_r <= 4'h0;
    end else begin
      st_r <= st_nxt;
      dec_r <= dec_nxt;
      cnt_r <= cnt_nxt;
      dcyc_r <= dcyc_nxt;
      dum_r <= dum_nxt;
      acyc_r <= acyc_nxt;
      tx_r <= tx_nxt;
      rx_r <= rx_nxt;
      rxn_r <= rxn_nxt;
      rd_r <= rd_nxt;
      rdv_r <= rdv_nxt;
      done_r <= done_nxt;
      quad_r <= quad_nxt;
      sclk_r <= sclk_nxt;
      cs_r <= cs_nxt;
      hc_r <= hc_nxt;
      last_r <= last_nxt;
      io_s1_r <= lnk.io;
      io_s2_r <= io_s1_r;
      hout_r <= hout_nxt;
      hoe_r <= hoe_nxt;
    end
  end

  // lanes move only with the falling clock or as chip select falls, never at the device's sampling edge
  assign lnk.h_out = hout_r;
  assign lnk.h_oe = hoe_r;

  assign lnk.sclk = sclk_r; // mode 0, low while idle
  assign lnk.cs_n = cs_r;
  assign o_busy = (st_r != H_IDLE);
  assign o_rd_data = rd_r;
  assign o_rd_valid = rdv_r;
  assign o_done = done_r;
endmodule

// ==== bench/fadm_assertions.sv ====
// link protocol checker between the two ends
`timescale 1ns/1ps
module fadm_assertions (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic [3:0] h_out,
  input wire logic [3:0] h_oe,
  input wire logic [3:0] d_out,
  input wire logic [3:0] d_oe
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  chk_sclk_idle_low: assert property (cs_n |-> !sclk)
    else $error("link clock not low while deselected");
  chk_dev_quiet: assert property (cs_n |-> d_oe == 4'h0)
    else $error("device drives lanes while deselected");
  chk_dev_fall_edge: assert property (!cs_n && $past(!cs_n) && $changed(d_out) |-> $fell(sclk))
    else $error("device data moved off a falling edge");
  chk_host_fall_edge: assert property (!cs_n && $past(!cs_n) && $changed(h_out) |-> $fell(sclk))
    else $error("host data moved off a falling edge");
  chk_half_period: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
    else $error("link clock high phase not four cycles");
  chk_cs_gap: assert property ($rose(cs_n) |-> cs_n [*6])
    else $error("deselect gap too short");
  chk_out_lanes: assert property (d_oe != 4'h0 |-> d_oe == 4'h2 || d_oe == 4'hF)
    else $error("device enables an odd lane set");
  chk_no_contention: assert property ((h_oe & d_oe) == 4'h0)
    else $error("both ends drive one lane");
  chk_oe_on_fall: assert property ($rose(|d_oe) |-> $fell(sclk))
    else $error("device output enabled off a falling edge");
  cover property ($rose(d_oe == 4'hF));
  cover property ($rose(d_oe == 4'h2));
  cover property ($rose(cs_n));
endmodule

// ==== bench/tb_top.sv ====
// testbench: host and flash ends joined over the link
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; $display("Error at %0t: got %0h expected %0h", $time, (g), (e)); end end
module tb_top;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic start = 1'b0, quad = 1'b0, wide = 1'b0, seg = 1'b0, ear_we = 1'b0, cfg_we = 1'b0;
  logic [7:0] opcode = 8'h00, len = 8'h00, ear_wd = 8'h00, cfg_wd = 8'h00, first_op, sh;
  logic [31:0] addr = 32'h00000000;
  logic [1:0] dc = 2'h0;
  logic busy, rd_valid, done, erq, quad_out;
  logic [7:0] rd_data, ear_rd, cfg_rd, mem_data;
  logic [31:0] mem_addr, er_addr_o, er_addr;
  fadm_pkg::fadm_kind_type er_kind_o, er_kind;
  int num_errors = 0, samples_checked = 0, er_cnt = 0, cycles = 0, bits = 0, seed = 47836;
  logic [7:0] rd_q[$];
  fadm_link_if lnk();
  fadm_host fadm_host_inst (.lnk(lnk.host), .i_clk(i_clk), .i_rst(i_rst), .i_start(start),
    .i_opcode(opcode), .i_addr(addr), .i_len(len), .i_quad_mode(quad), .i_wide_mode(wide),
    .i_dummy_code(dc), .o_busy(busy), .o_rd_data(rd_data), .o_rd_valid(rd_valid), .o_done(done));
  fadm_device fadm_device_inst (.lnk(lnk.dev), .i_clk(i_clk), .i_rst(i_rst), .i_ear_we(ear_we),
    .i_ear_wdata(ear_wd), .o_ear_rdata(ear_rd), .i_cfg_we(cfg_we), .i_cfg_wdata(cfg_wd),
    .o_cfg_rdata(cfg_rd), .o_quad_mode(quad_out), .o_mem_addr(mem_addr), .i_mem_data(mem_data),
    .o_erase_req(erq), .o_erase_kind(er_kind_o), .o_erase_addr(er_addr_o));
  fadm_assertions fadm_assertions_inst (.i_clk(i_clk), .i_rst(i_rst), .cs_n(lnk.cs_n),
    .sclk(lnk.sclk), .h_out(lnk.h_out), .h_oe(lnk.h_oe), .d_out(lnk.d_out), .d_oe(lnk.d_oe));
  // array content depends on bit 24 so a wrong segment shows
  function automatic logic [7:0] mem_byte(input logic [24:0] a);
    return a[7:0] ^ a[23:16] ^ {a[24], 2'h0, a[24], 4'h0};
  endfunction
  assign mem_data = mem_byte(mem_addr[24:0]);
  function automatic logic [24:0] res(input logic [7:0] op, input logic [31:0] a);
    if (wide || op inside {8'h13, 8'h0C, 8'h6C, 8'hEC, 8'h21, 8'h5C, 8'hDC})
      return a[24:0];
    return {seg, a[23:0]};
  endfunction
  initial begin
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 80000) begin
      num_errors++;
      final_report();
    end
  end
  always @(negedge lnk.cs_n) bits = 0;
  always @(posedge lnk.sclk) begin
    bits++;
    sh = {sh[6:0], lnk.io[0]};
    if (bits == 8) first_op = sh;
  end
  always @(posedge i_clk) begin
    if (rd_valid === 1'b1) rd_q.push_back(rd_data);
    if (erq === 1'b1) begin
      er_cnt++;
      er_kind = er_kind_o;
      er_addr = er_addr_o;
    end
  end
  task automatic final_report();
    $display("Checks: %0d, errors: %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // gap after done lets the device commit a mode before the next frame
  task automatic cmd(input logic [7:0] op, input logic [31:0] a, input logic [7:0] n);
    @(negedge i_clk);
    opcode = op;
    addr = a;
    len = n;
    start = 1'b1;
    rd_q.delete();
    @(negedge i_clk);
    start = 1'b0;
    `CHK(busy, 1'b1)
    while (done !== 1'b1) @(negedge i_clk);
    `CHK(busy, 1'b0)
    if (!quad) `CHK(first_op, op)
    repeat (8) @(negedge i_clk);
  endtask
  task automatic rd_chk(input logic [7:0] op, input logic [31:0] a, input logic [7:0] n);
    logic [24:0] ea;
    ea = res(op, a);
    cmd(op, a, n);
    `CHK(rd_q.size(), int'(n))
    for (int i = 0; i < n; i++) `CHK(rd_q[i], mem_byte(ea + 25'(i)))
  endtask
  task automatic er_chk(input logic [7:0] op, input logic [31:0] a,
                        input fadm_pkg::fadm_kind_type k);
    int c;
    logic [31:0] ea;
    c = er_cnt;
    ea = (k == fadm_pkg::K_CHIP) ? 32'h00000000 : {7'h00, res(op, a)};
    cmd(op, a, 8'h00);
    `CHK(er_cnt, c + 1)
    `CHK(er_kind, k)
    `CHK(er_addr, ea)
  endtask
  task automatic ear_set(input logic [7:0] v);
    @(negedge i_clk);
    ear_we = 1'b1;
    ear_wd = v;
    @(negedge i_clk);
    ear_we = 1'b0;
    seg = v[0];
    `CHK(ear_rd, {7'h00, v[0]})
  endtask
  task automatic cfg_set(input logic [1:0] v);
    @(negedge i_clk);
    cfg_we = 1'b1;
    cfg_wd = {v, 6'h00};
    @(negedge i_clk);
    cfg_we = 1'b0;
    dc = v;
    `CHK(cfg_rd[7:6], v)
  endtask
  initial begin
    logic [7:0] ops[8] = '{8'h03, 8'h13, 8'h0B, 8'h0C, 8'h6B, 8'h6C, 8'hEB, 8'hEC};
    logic [7:0] eops[6] = '{8'h20, 8'h52, 8'hD8, 8'h21, 8'h5C, 8'hDC};
    fadm_pkg::fadm_kind_type ek[3] = '{fadm_pkg::K_SECTOR, fadm_pkg::K_HALF_BLOCK,
                                       fadm_pkg::K_BLOCK};
    int k;
    repeat (4) @(negedge i_clk);
    i_rst = 1'b0;
    `CHK(ear_rd, 8'h00)
    `CHK(cfg_rd, 8'h00)
    `CHK(quad_out, 1'b0)
    for (int i = 0; i < 8; i++) begin
      cfg_set(2'(i));
      ear_set({7'h7F, i[1]});
      rd_chk(ops[i], $random(seed), 8'h03);
    end
    ear_set(8'h00);
    rd_chk(8'h03, 32'h00FFFFFE, 8'h04);
    `CHK(ear_rd, 8'h00)
    ear_set(8'h01);
    rd_chk(8'h0B, 32'h00000010, 8'h02);
    cmd(8'h9A, 32'h00000000, 8'h02);
    `CHK(rd_q.size(), 0)
    for (int i = 0; i < 6; i++) er_chk(eops[i], $random(seed), ek[i % 3]);
    er_chk(8'h60, 32'h00123456, fadm_pkg::K_CHIP);
    er_chk(8'hC7, 32'h00000000, fadm_pkg::K_CHIP);
    cmd(fadm_pkg::OP_ENTER_WIDE, 32'h00000000, 8'h00);
    wide = 1'b1;
    `CHK(cfg_rd[5], 1'b1)
    rd_chk(8'h03, 32'h00ABCDEF, 8'h02);
    er_chk(8'h20, 32'h00F00000, fadm_pkg::K_SECTOR);
    cmd(fadm_pkg::OP_ENTER_QUAD, 32'h00000000, 8'h00);
    quad = 1'b1;
    `CHK(quad_out, 1'b1)
    rd_chk(8'hEB, $random(seed), 8'h02);
    // single-line read refused in four-line mode: host clocks on, lanes stay pulled up
    cmd(8'h03, $random(seed), 8'h02);
    `CHK(rd_q.size(), 2)
    foreach (rd_q[i]) `CHK(rd_q[i], 8'hFF)
    er_chk(8'hD8, $random(seed), fadm_pkg::K_BLOCK);
    cmd(fadm_pkg::OP_QUAD_RESET, 32'h00000000, 8'h00);
    quad = 1'b0;
    `CHK(quad_out, 1'b0)
    cmd(fadm_pkg::OP_EXIT_WIDE, 32'h00000000, 8'h00);
    wide = 1'b0;
    `CHK(cfg_rd[5], 1'b0)
    repeat (12) begin
      k = $random(seed);
      cfg_set(k[1:0]);
      ear_set(8'(k >> 4));
      rd_chk(ops[k[10:8]], $random(seed), 8'(k[13:12]) + 8'h01);
    end
    final_report();
  end
endmodule
